// *** rtl/charger_option_control_regs.sv ***
// charger option control and status logic behind two host registers
// Operation
// - limit pin low enters high-impedance when select is 0, pass-through when 1
// - reference select: 0 picks 2.3V (reset), 1 picks 1.2V
// - polarity 0: output low when input above reference; 1: when below
// - deglitch code 00 disables comparator; 01/10/11 give 1us/2ms/5s; reset 01
// - deglitch delays only the falling edge of comparator output
// - latch-off on comparator trip opens switches one and four, drops charge-ok
// - latch-off holds until the adapter is removed
// - pass-through enable bit turns pass-through on; reset 0
// - shipping discharge runs 140ms then its bit clears itself
// - auto wakeup charges 128mA up to 30min; clears bit when battery recovers
// - overload time codes give 1, 2, 10, 20ms; reset 00
// - peak mode entered only on enabled triggers; off when both disabled
// - adapter removal clears both peak trigger enables
// - overload status set in overload cycle; writing 0 leaves it
// - relax status set in relax cycle; writing 0 leaves it
// - cycle time codes give 5, 10, 20, 40ms; reset 10
// - overload longer than cycle time skips relax period
// - external limit enabled: input limit is smallest of three limits
// - monitor direction 0 reports discharge, 1 reports charge; reset 0
// - low-side and input-sense over-current levels selected by one bit each
// - input over-current disables converter after 100us blank-out; 133/200% level
// - discharge over-current disables converter; 133/200% level selectable
`timescale 1ns/1ps
`default_nettype none

module charger_option_control_regs #(
	parameter int     LIMIT_W        = 8,
	parameter longint DEG_2MS_CYCLES = charger_option_pkg::DEG_2MS_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint DEG_5S_CYCLES  = charger_option_pkg::DEG_5S_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint SHIP_CYCLES    = charger_option_pkg::SHIP_140MS_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint WAKE_CYCLES    = charger_option_pkg::WAKE_30MIN_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint BLANK_CYCLES   = charger_option_pkg::BLANK_100US_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint PEAK_1MS_CYC   = charger_option_pkg::PEAK_1MS_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint PEAK_2MS_CYC   = charger_option_pkg::PEAK_2MS_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint PEAK_5MS_CYC   = charger_option_pkg::PEAK_5MS_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint PEAK_10MS_CYC  = charger_option_pkg::PEAK_10MS_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint PEAK_20MS_CYC  = charger_option_pkg::PEAK_20MS_NS / charger_option_pkg::CLOCK_PERIOD_NS,
	parameter longint PEAK_40MS_CYC  = charger_option_pkg::PEAK_40MS_NS / charger_option_pkg::CLOCK_PERIOD_NS
) (
	// clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_sys_rst,
	// register access
	input  wire logic               i_reg_write,
	input  wire logic               i_reg_read,
	input  wire logic [7:0]         i_reg_command,
	input  wire logic [15:0]        i_reg_wdata,
	output logic      [15:0]        o_reg_rdata,
	output logic                    o_reg_read_valid,
	// asynchronous pins and sense comparators
	input  wire logic               i_external_limit_pin,
	input  wire logic               i_comparator_input_above,
	input  wire logic               i_adapter_present,
	input  wire logic               i_battery_below_minimum,
	input  wire logic               i_input_overshoot,
	input  wire logic               i_system_undershoot,
	input  wire logic               i_input_overcurrent,
	input  wire logic               i_discharge_overcurrent,
	// input current limit codes
	input  wire logic [LIMIT_W-1:0] i_external_limit_code,
	input  wire logic [LIMIT_W-1:0] i_dynamic_input_limit,
	input  wire logic [LIMIT_W-1:0] i_host_limit_code,
	output logic      [LIMIT_W-1:0] o_input_limit_code,
	// comparator and power path
	output logic                    o_comparator_reference_select,
	output logic                    o_comparator_output,
	output logic                    o_first_power_switch_on,
	output logic                    o_fourth_power_switch_on,
	output logic                    o_charge_ok_indication,
	output logic                    o_converter_enable,
	output logic                    o_high_impedance_mode,
	output logic                    o_pass_through_mode,
	output logic                    o_shipping_discharge,
	output logic                    o_wakeup_charge,
	output logic                    o_peak_overload,
	output logic                    o_peak_relax,
	// analog settings
	output logic                    o_battery_monitor_direction,
	output logic                    o_low_side_switch_overcurrent_level,
	output logic                    o_input_sense_overcurrent_level,
	output logic                    o_input_overcurrent_level,
	output logic                    o_discharge_overcurrent_level
);

	localparam int TW = charger_option_pkg::TIMER_W;
	typedef enum logic [1:0] {PEAK_IDLE, PEAK_OVERLOAD, PEAK_RELAX} peak_state_t;

	// ==========================================
	// functions
	function automatic logic [TW-1:0] deglitch_cycles(input logic [1:0] code);
		unique case (code)
			charger_option_pkg::COMPARATOR_DEGLITCH_SELECT_1US: deglitch_cycles = TW'(charger_option_pkg::DEG_1US_CYCLES);
			charger_option_pkg::COMPARATOR_DEGLITCH_SELECT_2MS: deglitch_cycles = TW'(DEG_2MS_CYCLES);
			default:                         deglitch_cycles = TW'(DEG_5S_CYCLES);
		endcase
	endfunction : deglitch_cycles

	function automatic logic [TW-1:0] overload_cycles(input logic [1:0] code);
		unique case (code)
			2'h0: overload_cycles = TW'(PEAK_1MS_CYC);
			2'h1: overload_cycles = TW'(PEAK_2MS_CYC);
			2'h2: overload_cycles = TW'(PEAK_10MS_CYC);
			2'h3: overload_cycles = TW'(PEAK_20MS_CYC);
		endcase
	endfunction : overload_cycles

	function automatic logic [TW-1:0] cycle_cycles(input logic [1:0] code);
		unique case (code)
			2'h0: cycle_cycles = TW'(PEAK_5MS_CYC);
			2'h1: cycle_cycles = TW'(PEAK_10MS_CYC);
			2'h2: cycle_cycles = TW'(PEAK_20MS_CYC);
			2'h3: cycle_cycles = TW'(PEAK_40MS_CYC);
		endcase
	endfunction : cycle_cycles

	function automatic logic [LIMIT_W-1:0] min_code(input logic [LIMIT_W-1:0] a, input logic [LIMIT_W-1:0] b);
		min_code = (a < b) ? a : b;
	endfunction : min_code

	// ==========================================
	// pin synchronisers
	logic [7:0] sync_a_reg;
	logic [7:0] sync_b_reg;
	logic       adapter_last_reg;
	logic       limit_pin;
	logic       cmp_above;
	logic       adapter;
	logic       below_min;
	logic       overshoot;
	logic       undershoot;
	logic       in_oc;
	logic       dis_oc;
	logic       adapter_fall;

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync_a_reg       <= charger_option_pkg::SYNC_RESET;
			sync_b_reg       <= charger_option_pkg::SYNC_RESET;
			adapter_last_reg <= 1'b0;
		end else begin
			sync_a_reg       <= {i_discharge_overcurrent, i_input_overcurrent, i_system_undershoot,
				i_input_overshoot, i_battery_below_minimum, i_adapter_present,
				i_comparator_input_above, i_external_limit_pin};
			sync_b_reg       <= sync_a_reg;
			adapter_last_reg <= sync_b_reg[2];
		end
	end

	assign limit_pin    = sync_b_reg[0];
	assign cmp_above    = sync_b_reg[1];
	assign adapter      = sync_b_reg[2];
	assign below_min    = sync_b_reg[3];
	assign overshoot    = sync_b_reg[4];
	assign undershoot   = sync_b_reg[5];
	assign in_oc        = sync_b_reg[6];
	assign dis_oc       = sync_b_reg[7];
	assign adapter_fall = adapter_last_reg & ~adapter;

	// ==========================================
	// state registers
	logic [15:0]   opt_one_reg, opt_one_next;
	logic [15:0]   opt_two_reg, opt_two_next;
	logic          cmp_out_reg, cmp_out_next;
	logic [TW-1:0] deg_cnt_reg, deg_cnt_next;
	logic          latch_reg, latch_next;
	logic [TW-1:0] ship_cnt_reg, ship_cnt_next;
	logic          wake_reg, wake_next;
	logic          wake_done_reg, wake_done_next;
	logic [TW-1:0] wake_cnt_reg, wake_cnt_next;
	peak_state_t   peak_reg, peak_next;
	logic [TW-1:0] peak_cnt_reg, peak_cnt_next;
	logic [TW-1:0] blank_cnt_reg, blank_cnt_next;
	logic          acoc_fault_reg, acoc_fault_next;
	logic          batoc_fault_reg, batoc_fault_next;

	logic          wr_one, wr_two, cmp_enabled, cmp_low_cond, trip, trig_any, trig_hit;
	logic [1:0]    deg_code;
	logic [TW-1:0] ovld_t, cyc_t;

	always_comb begin
		wr_one       = i_reg_write && (i_reg_command == charger_option_pkg::OPTION_ONE_ADDR);
		wr_two       = i_reg_write && (i_reg_command == charger_option_pkg::OPTION_TWO_ADDR);
		deg_code     = opt_one_reg[charger_option_pkg::COMPARATOR_DEGLITCH_SELECT_LSB +: 2];
		cmp_enabled  = (deg_code != charger_option_pkg::COMPARATOR_DEGLITCH_SELECT_OFF);
		cmp_low_cond = opt_one_reg[charger_option_pkg::COMPARATOR_POLARITY_BIT] ? ~cmp_above : cmp_above;
		trip         = cmp_enabled & ~cmp_out_reg;
		trig_any     = opt_two_reg[charger_option_pkg::TRIG_CUR_BIT] | opt_two_reg[charger_option_pkg::TRIG_VOLT_BIT];
		trig_hit     = (opt_two_reg[charger_option_pkg::TRIG_CUR_BIT] & overshoot)
			| (opt_two_reg[charger_option_pkg::TRIG_VOLT_BIT] & undershoot);
		ovld_t       = overload_cycles(opt_two_reg[charger_option_pkg::TOVLD_LSB +: 2]);
		cyc_t        = cycle_cycles(opt_two_reg[charger_option_pkg::TMAX_LSB +: 2]);

		opt_one_next = wr_one ? i_reg_wdata : opt_one_reg;
		// status bits live in the state machine, never stored
		opt_two_next = wr_two ? (i_reg_wdata & ~charger_option_pkg::OPTION_TWO_STATUS_M) : opt_two_reg;
		if (adapter_fall) begin
			opt_two_next[charger_option_pkg::TRIG_CUR_BIT]  = 1'b0;
			opt_two_next[charger_option_pkg::TRIG_VOLT_BIT] = 1'b0;
		end

		// falling edge filtered, rising passes at once
		cmp_out_next = 1'b1;
		deg_cnt_next = '0;
		if (cmp_enabled && cmp_low_cond) begin
			if (!cmp_out_reg) begin
				cmp_out_next = 1'b0;
			end else if (deg_cnt_reg + TW'(1) >= deglitch_cycles(deg_code)) begin
				cmp_out_next = 1'b0;
			end else begin
				deg_cnt_next = deg_cnt_reg + TW'(1);
			end
		end

		// held until adapter leaves; a trip wins
		latch_next = latch_reg & adapter;
		if (opt_one_reg[charger_option_pkg::LATCHOFF_BIT] && trip) begin
			latch_next = 1'b1;
		end

		ship_cnt_next = '0;
		if (opt_one_reg[charger_option_pkg::SHIP_BIT] && !wr_one) begin
			if (ship_cnt_reg + TW'(1) >= TW'(SHIP_CYCLES)) begin
				opt_one_next[charger_option_pkg::SHIP_BIT] = 1'b0;
			end else begin
				ship_cnt_next = ship_cnt_reg + TW'(1);
			end
		end

		wake_next      = wake_reg;
		wake_done_next = wake_done_reg & below_min;
		wake_cnt_next  = '0;
		if (wake_reg) begin
			if (!below_min) begin
				wake_next = 1'b0;
				if (!(wr_one && i_reg_wdata[charger_option_pkg::WAKE_BIT])) begin
					opt_one_next[charger_option_pkg::WAKE_BIT] = 1'b0;
				end
			end else if (wake_cnt_reg + TW'(1) >= TW'(WAKE_CYCLES)) begin
				wake_next      = 1'b0;
				wake_done_next = 1'b1;
			end else begin
				wake_cnt_next = wake_cnt_reg + TW'(1);
			end
		end else if (opt_one_reg[charger_option_pkg::WAKE_BIT] && below_min && !wake_done_reg) begin
			wake_next = 1'b1;
		end

		// a 0 written to a status bit, or both triggers disabled, ends the cycle early
		peak_next     = peak_reg;
		peak_cnt_next = peak_cnt_reg + TW'(1);
		unique case (peak_reg)
			PEAK_IDLE: begin
				peak_cnt_next = '0;
				if (trig_hit) begin
					peak_next = PEAK_OVERLOAD;
				end
			end
			PEAK_OVERLOAD: begin
				if (!trig_any || (wr_two && !i_reg_wdata[charger_option_pkg::OVLD_STAT_BIT])) begin
					peak_next = PEAK_IDLE;
				end else if (peak_cnt_reg + TW'(1) >= ovld_t) begin
					// no relax when overload outlasts cycle
					peak_next = (ovld_t >= cyc_t) ? PEAK_IDLE : PEAK_RELAX;
				end
			end
			PEAK_RELAX: begin
				// overload plus relax spans cycle time
				if (!trig_any || (wr_two && !i_reg_wdata[charger_option_pkg::RELAX_STAT_BIT])
					|| (peak_cnt_reg + TW'(1) >= cyc_t)) begin
					peak_next = PEAK_IDLE;
				end
			end
			default: peak_next = PEAK_IDLE;
		endcase

		acoc_fault_next = acoc_fault_reg & adapter;
		blank_cnt_next  = '0;
		if (opt_two_reg[charger_option_pkg::ACOC_EN_BIT] && in_oc && !acoc_fault_reg) begin
			if (blank_cnt_reg + TW'(1) >= TW'(BLANK_CYCLES)) begin
				acoc_fault_next = 1'b1;
			end else begin
				blank_cnt_next = blank_cnt_reg + TW'(1);
			end
		end
		batoc_fault_next = (batoc_fault_reg & adapter)
			| (opt_two_reg[charger_option_pkg::BATOC_EN_BIT] & dis_oc);
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			opt_one_reg     <= charger_option_pkg::OPTION_ONE_RESET;
			opt_two_reg     <= charger_option_pkg::OPTION_TWO_RESET;
			cmp_out_reg     <= 1'b1;
			deg_cnt_reg     <= '0;
			latch_reg       <= 1'b0;
			ship_cnt_reg    <= '0;
			wake_reg        <= 1'b0;
			wake_done_reg   <= 1'b0;
			wake_cnt_reg    <= '0;
			peak_reg        <= PEAK_IDLE;
			peak_cnt_reg    <= '0;
			blank_cnt_reg   <= '0;
			acoc_fault_reg  <= 1'b0;
			batoc_fault_reg <= 1'b0;
		end else begin
			opt_one_reg     <= opt_one_next;
			opt_two_reg     <= opt_two_next;
			cmp_out_reg     <= cmp_out_next;
			deg_cnt_reg     <= deg_cnt_next;
			latch_reg       <= latch_next;
			ship_cnt_reg    <= ship_cnt_next;
			wake_reg        <= wake_next;
			wake_done_reg   <= wake_done_next;
			wake_cnt_reg    <= wake_cnt_next;
			peak_reg        <= peak_next;
			peak_cnt_reg    <= peak_cnt_next;
			blank_cnt_reg   <= blank_cnt_next;
			acoc_fault_reg  <= acoc_fault_next;
			batoc_fault_reg <= batoc_fault_next;
		end
	end

	// ==========================================
	// registered outputs
	logic [15:0] read_word;
	logic        pin_low;

	always_comb begin
		pin_low   = ~limit_pin;
		read_word = 16'h0000;
		if (i_reg_command == charger_option_pkg::OPTION_ONE_ADDR) begin
			read_word = opt_one_reg;
		end else if (i_reg_command == charger_option_pkg::OPTION_TWO_ADDR) begin
			read_word = opt_two_reg;
			read_word[charger_option_pkg::OVLD_STAT_BIT]  = (peak_reg == PEAK_OVERLOAD);
			read_word[charger_option_pkg::RELAX_STAT_BIT] = (peak_reg == PEAK_RELAX);
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_reg_rdata                         <= 16'h0000;
			o_reg_read_valid                    <= 1'b0;
			o_input_limit_code                  <= '0;
			o_comparator_reference_select       <= 1'b0;
			o_comparator_output                 <= 1'b1;
			o_first_power_switch_on             <= 1'b0;
			o_fourth_power_switch_on            <= 1'b0;
			o_charge_ok_indication              <= 1'b0;
			o_converter_enable                  <= 1'b0;
			o_high_impedance_mode               <= 1'b0;
			o_pass_through_mode                 <= 1'b0;
			o_shipping_discharge                <= 1'b0;
			o_wakeup_charge                     <= 1'b0;
			o_peak_overload                     <= 1'b0;
			o_peak_relax                        <= 1'b0;
			o_battery_monitor_direction         <= 1'b0;
			o_low_side_switch_overcurrent_level <= 1'b1;
			o_input_sense_overcurrent_level     <= 1'b1;
			o_input_overcurrent_level           <= 1'b1;
			o_discharge_overcurrent_level       <= 1'b1;
		end else begin
			o_reg_rdata                         <= i_reg_read ? read_word : o_reg_rdata;
			o_reg_read_valid                    <= i_reg_read;
			o_input_limit_code                  <= opt_two_reg[charger_option_pkg::EXTLIM_BIT]
				? min_code(i_external_limit_code, min_code(i_dynamic_input_limit, i_host_limit_code))
				: min_code(i_dynamic_input_limit, i_host_limit_code);
			o_comparator_reference_select       <= opt_one_reg[charger_option_pkg::COMPARATOR_REFERENCE_SELECT_BIT];
			o_comparator_output                 <= cmp_out_reg;
			o_first_power_switch_on             <= adapter & ~latch_reg;
			o_fourth_power_switch_on            <= adapter & ~latch_reg;
			o_charge_ok_indication              <= adapter & ~latch_reg;
			o_converter_enable                  <= adapter & ~latch_reg & ~acoc_fault_reg & ~batoc_fault_reg;
			o_high_impedance_mode               <= pin_low & ~opt_one_reg[charger_option_pkg::PINSEL_BIT];
			o_pass_through_mode                 <= opt_one_reg[charger_option_pkg::PTM_EN_BIT]
				| (pin_low & opt_one_reg[charger_option_pkg::PINSEL_BIT]);
			o_shipping_discharge                <= opt_one_reg[charger_option_pkg::SHIP_BIT];
			o_wakeup_charge                     <= wake_reg;
			o_peak_overload                     <= (peak_reg == PEAK_OVERLOAD);
			o_peak_relax                        <= (peak_reg == PEAK_RELAX);
			o_battery_monitor_direction         <= opt_two_reg[charger_option_pkg::MON_DIR_BIT];
			o_low_side_switch_overcurrent_level <= opt_two_reg[charger_option_pkg::LOWSIDE_BIT];
			o_input_sense_overcurrent_level     <= opt_two_reg[charger_option_pkg::INSENSE_BIT];
			o_input_overcurrent_level           <= opt_two_reg[charger_option_pkg::ACOC_LVL_BIT];
			o_discharge_overcurrent_level       <= opt_two_reg[charger_option_pkg::BATOC_LVL_BIT];
		end
	end

endmodule : charger_option_control_regs

`default_nettype wire

// *** rtl/charger_option_pkg.sv ***
// constants for the charger option control registers
package charger_option_pkg;

	// ==========================================
	// register map
	localparam logic [7:0]  OPTION_ONE_ADDR     = 8'h30;
	localparam logic [7:0]  OPTION_TWO_ADDR     = 8'h31;
	localparam logic [15:0] OPTION_ONE_RESET    = 16'h0211;
	localparam logic [15:0] OPTION_TWO_RESET    = 16'h02B7;
	localparam logic [15:0] OPTION_TWO_STATUS_M = 16'h0C00;

	// ==========================================
	// first option register fields
	localparam int PINSEL_BIT   = 8;
	localparam int COMPARATOR_REFERENCE_SELECT_BIT  = 7;
	localparam int COMPARATOR_POLARITY_BIT  = 6;
	localparam int COMPARATOR_DEGLITCH_SELECT_LSB  = 4;
	localparam int LATCHOFF_BIT = 3;
	localparam int PTM_EN_BIT   = 2;
	localparam int SHIP_BIT     = 1;
	localparam int WAKE_BIT     = 0;

	// ==========================================
	// second option register fields
	localparam int TOVLD_LSB      = 14;
	localparam int TRIG_CUR_BIT   = 13;
	localparam int TRIG_VOLT_BIT  = 12;
	localparam int OVLD_STAT_BIT  = 11;
	localparam int RELAX_STAT_BIT = 10;
	localparam int TMAX_LSB       = 8;
	localparam int EXTLIM_BIT     = 7;
	localparam int MON_DIR_BIT    = 6;
	localparam int LOWSIDE_BIT    = 5;
	localparam int INSENSE_BIT    = 4;
	localparam int ACOC_EN_BIT    = 3;
	localparam int ACOC_LVL_BIT   = 2;
	localparam int BATOC_EN_BIT   = 1;
	localparam int BATOC_LVL_BIT  = 0;

	localparam logic [1:0] COMPARATOR_DEGLITCH_SELECT_OFF = 2'h0;
	localparam logic [1:0] COMPARATOR_DEGLITCH_SELECT_1US = 2'h1;
	localparam logic [1:0] COMPARATOR_DEGLITCH_SELECT_2MS = 2'h2;

	// ==========================================
	// timing
	localparam int     TIMER_W         = 40;
	localparam longint CLOCK_PERIOD_NS = 10;
	localparam longint DEG_1US_NS      = 1000;
	localparam longint DEG_2MS_NS      = 2000000;
	localparam longint DEG_5S_NS       = 64'h12A05F200;
	localparam longint SHIP_140MS_NS   = 140000000;
	localparam longint WAKE_30MIN_NS   = 64'h1A3185C5000;
	localparam longint BLANK_100US_NS  = 100000;
	localparam longint PEAK_1MS_NS     = 1000000;
	localparam longint PEAK_2MS_NS     = 2000000;
	localparam longint PEAK_5MS_NS     = 5000000;
	localparam longint PEAK_10MS_NS    = 10000000;
	localparam longint PEAK_20MS_NS    = 20000000;
	localparam longint PEAK_40MS_NS    = 40000000;
	localparam longint DEG_1US_CYCLES  = (DEG_1US_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// pins idle with limit pin high, all else low
	localparam logic [7:0] SYNC_RESET = 8'h01;

endpackage : charger_option_pkg

// *** tb/charger_host_model.sv ***
// host controller model issuing register word accesses
`timescale 1ns/1ps
`default_nettype none
module charger_host_model (
	// clock and answer
	input  wire logic        i_clock,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_valid,
	// request
	output logic             o_write = 1'b0,
	output logic             o_read = 1'b0,
	output logic [7:0]       o_command = 8'h00,
	output logic [15:0]      o_wdata = 16'h0000
);
	task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
		@(posedge i_clock) #1;
		o_command = cmd;
		o_wdata = data;
		o_write = 1'b1;
		@(posedge i_clock) #1;
		o_write = 1'b0;
	endtask : wr
	// data taken while valid stands
	task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
		@(posedge i_clock) #1;
		o_command = cmd;
		o_read = 1'b1;
		@(posedge i_clock) #1;
		o_read = 1'b0;
		data = (i_valid === 1'b1) ? i_rdata : 16'hXXXX;
	endtask : rd
endmodule : charger_host_model
`default_nettype wire

// *** tb/charger_option_control_regs_properties.sv ***
// checker for the charger option control registers
`timescale 1ns/1ps
`default_nettype none
module charger_option_control_regs_properties #(
	parameter int     LIMIT_W     = 8,
	parameter longint SHIP_CYCLES = 50
) (
	// clock, reset and inputs
	input wire logic               i_clock,
	input wire logic               i_sys_rst,
	input wire logic               i_reg_write,
	input wire logic [7:0]         i_reg_command,
	input wire logic               i_external_limit_pin,
	input wire logic               i_adapter_present,
	input wire logic               i_battery_below_minimum,
	input wire logic [LIMIT_W-1:0] i_dynamic_input_limit,
	input wire logic [LIMIT_W-1:0] i_host_limit_code,
	// outputs watched
	input wire logic [LIMIT_W-1:0] o_input_limit_code,
	input wire logic               o_first_power_switch_on,
	input wire logic               o_fourth_power_switch_on,
	input wire logic               o_charge_ok_indication,
	input wire logic               o_converter_enable,
	input wire logic               o_high_impedance_mode,
	input wire logic               o_shipping_discharge,
	input wire logic               o_wakeup_charge,
	input wire logic               o_peak_overload,
	input wire logic               o_peak_relax
);
	// ==========================================
	// shipping run length, a write restarts it
	logic [31:0] ship_cnt_reg;
	logic [31:0] ship_cnt_next;
	always_comb begin
		ship_cnt_next = ship_cnt_reg + 32'h1;
		if (!o_shipping_discharge || (i_reg_write && i_reg_command == 8'h30)) ship_cnt_next = 32'h0;
	end
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) ship_cnt_reg <= 32'h0;
		else ship_cnt_reg <= ship_cnt_next;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	AST_PIN_HIGH: assert property (i_external_limit_pin [*5] |-> !o_high_impedance_mode)
		else $error("high impedance with limit pin high");
	AST_SWITCH_PAIR: assert property (o_first_power_switch_on == o_charge_ok_indication
		&& o_fourth_power_switch_on == o_charge_ok_indication) else $error("switches and charge ok differ");
	AST_CONV_PATH: assert property (o_converter_enable |-> o_charge_ok_indication)
		else $error("converter on with path off");
	AST_NO_ADAPTER: assert property (!i_adapter_present [*6] |-> !o_charge_ok_indication)
		else $error("charge ok without adapter");
	AST_SHIP_LEN: assert property (ship_cnt_reg <= SHIP_CYCLES + 2)
		else $error("shipping discharge too long");
	AST_WAKE_GONE: assert property (!i_battery_below_minimum [*6] |-> !o_wakeup_charge)
		else $error("wake charge with battery above minimum");
	AST_PEAK_ONE: assert property (!(o_peak_overload && o_peak_relax))
		else $error("overload and relax together");
	AST_LIMIT_MIN: assert property (o_input_limit_code <= $past(i_dynamic_input_limit)
		&& o_input_limit_code <= $past(i_host_limit_code)) else $error("input limit above minimum");
endmodule : charger_option_control_regs_properties
bind charger_option_control_regs charger_option_control_regs_properties #(
	.LIMIT_W(LIMIT_W), .SHIP_CYCLES(SHIP_CYCLES)) u_props (.i_clock, .i_sys_rst, .i_reg_write,
	.i_reg_command, .i_external_limit_pin, .i_adapter_present, .i_battery_below_minimum,
	.i_dynamic_input_limit, .i_host_limit_code, .o_input_limit_code, .o_first_power_switch_on,
	.o_fourth_power_switch_on, .o_charge_ok_indication, .o_converter_enable, .o_high_impedance_mode,
	.o_shipping_discharge, .o_wakeup_charge, .o_peak_overload, .o_peak_relax);
`default_nettype wire

// *** tb/charger_option_control_regs_tb.sv ***
// testbench for the charger option control registers
`timescale 1ns/1ps
`default_nettype none
module charger_option_control_regs_tb;
	logic clk = 1'b0, rst = 1'b1, pin = 1'b1, cmp = 1'b0, adp = 1'b1, low = 1'b0, ovs = 1'b0;
	logic uds = 1'b0, ioc = 1'b0, doc = 1'b0, wr_s, rd_s, vld, sw1, cok, high_impedance_mode, ship, wake;
	logic [7:0] cmd, lim, ext = 8'h30, dyn = 8'h20, hst = 8'h10;
	wire [7:0] o8;
	logic [15:0] wd, rdata, got;
	int fail_count = 0, n_tests = 0, cycles = 0;
	always #5 clk = ~clk;
	charger_host_model u_host (.i_clock(clk), .i_rdata(rdata), .i_valid(vld), .o_write(wr_s),
		.o_read(rd_s), .o_command(cmd), .o_wdata(wd));
	charger_option_control_regs #(.DEG_2MS_CYCLES(200), .DEG_5S_CYCLES(500), .SHIP_CYCLES(50),
		.WAKE_CYCLES(80), .BLANK_CYCLES(20), .PEAK_1MS_CYC(10), .PEAK_2MS_CYC(20), .PEAK_5MS_CYC(50),
		.PEAK_10MS_CYC(100), .PEAK_20MS_CYC(200), .PEAK_40MS_CYC(400)) u_dut (.i_clock(clk),
		.i_sys_rst(rst), .i_reg_write(wr_s), .i_reg_read(rd_s), .i_reg_command(cmd), .i_reg_wdata(wd),
		.o_reg_rdata(rdata), .o_reg_read_valid(vld), .i_external_limit_pin(pin),
		.i_comparator_input_above(cmp), .i_adapter_present(adp), .i_battery_below_minimum(low),
		.i_input_overshoot(ovs), .i_system_undershoot(uds), .i_input_overcurrent(ioc),
		.i_discharge_overcurrent(doc), .i_external_limit_code(ext), .i_dynamic_input_limit(dyn),
		.i_host_limit_code(hst), .o_input_limit_code(lim), .o_comparator_reference_select(o8[0]),
		.o_comparator_output(o8[1]), .o_first_power_switch_on(sw1), .o_fourth_power_switch_on(),
		.o_charge_ok_indication(cok), .o_converter_enable(o8[2]), .o_high_impedance_mode(high_impedance_mode),
		.o_pass_through_mode(o8[3]), .o_shipping_discharge(ship), .o_wakeup_charge(wake),
		.o_peak_overload(o8[6]), .o_peak_relax(o8[7]), .o_battery_monitor_direction(o8[4]),
		.o_low_side_switch_overcurrent_level(), .o_input_sense_overcurrent_level(o8[5]),
		.o_input_overcurrent_level(), .o_discharge_overcurrent_level());
	// ==========================================
	// checking and closing
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		u_host.rd(a, got);
		check("register word", got, exp);
	endtask : rdc
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	// hang guard, tests take ~540 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles > 4000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		wt(4);
		rst = 1'b0;
		rdc(8'h30, 16'h0211);
		rdc(8'h31, 16'h02B7);
		rdc(8'h40, 16'h0000);
		ext = 8'h05;
		wt(3);
		check("limit", 16'(lim), 16'h0005);
		dyn = 8'h08;
		u_host.wr(8'h31, 16'h0237);
		wt(3);
		check("limit", 16'(lim), 16'h0008);
		u_host.wr(8'h31, 16'hFFFF);
		rdc(8'h31, 16'hF3FF);
		check("outputs", 16'(o8), 16'h36);
		u_host.wr(8'h31, 16'hE0B7);
		ovs = 1'b1;
		wt(3);
		ovs = 1'b0;
		wt(4);
		rdc(8'h31, 16'hE8B7);
		check("outputs", 16'(o8), 16'h66);
		u_host.wr(8'h31, 16'hE0B7);
		rdc(8'h31, 16'hE0B7);
		ovs = 1'b1;
		wt(3);
		ovs = 1'b0;
		wt(230);
		rdc(8'h31, 16'hE0B7);
		u_host.wr(8'h31, 16'h32B7);
		ovs = 1'b1;
		wt(3);
		ovs = 1'b0;
		wt(20);
		rdc(8'h31, 16'h36B7);
		check("outputs", 16'(o8), 16'hA6);
		u_host.wr(8'h31, 16'h32B7);
		rdc(8'h31, 16'h32B7);
		adp = 1'b0;
		wt(8);
		rdc(8'h31, 16'h02B7);
		adp = 1'b1;
		u_host.wr(8'h30, 16'h0213);
		wt(3);
		check("shipping", 16'(ship), 16'h0001);
		wt(60);
		rdc(8'h30, 16'h0211);
		u_host.wr(8'h30, 16'h0219);
		check("charge ok", 16'(cok), 16'h0001);
		cmp = 1'b1;
		wt(110);
		check("switch one", 16'(sw1), 16'h0000);
		cmp = 1'b0;
		wt(10);
		check("charge ok", 16'(cok), 16'h0000);
		check("outputs", 16'(o8), 16'h22);
		adp = 1'b0;
		wt(8);
		adp = 1'b1;
		wt(8);
		check("charge ok", 16'(cok), 16'h0001);
		low = 1'b1;
		wt(6);
		check("wake", 16'(wake), 16'h0001);
		low = 1'b0;
		wt(6);
		rdc(8'h30, 16'h0218);
		pin = 1'b0;
		wt(5);
		check("high impedance", 16'(high_impedance_mode), 16'h0001);
		u_host.wr(8'h30, 16'h0180);
		wt(3);
		check("outputs", 16'(o8), 16'h2F);
		close_out();
	end
endmodule : charger_option_control_regs_tb
`default_nettype wire
